// ==== bench/caf_assertions.sv ====
`timescale 1ns/1ns
module caf_chk
#(
	parameter int NUM_FILTERS = 16
)
(
	input wire logic CLK,
	input wire logic NRST,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [11:0] PADDR,
	input wire logic [31:0] PWDATA,
	input wire logic PREADY,
	input wire logic PSLVERR,
	input wire logic [31:0] PRDATA,
	input wire caf_pkg::caf_mask_s [2:0] MASKS,
	input wire logic [47:0] PTR_LOW,
	input wire logic [15:0] MSEL_HIGH,
	input wire caf_pkg::caf_frame_s FRAME,
	input wire caf_pkg::caf_hit_s RESULT
);
	import caf_pkg::*;
	default clocking @(posedge CLK);
	endclocking
	default disable iff (!NRST);
	////////////////////
	a_ready_answer: assert property ($rose(PENABLE) && PSEL |-> ##1 !PREADY ##1 PREADY)
		else $error("ready late");
	a_ready_pulse: assert property (PREADY |=> !PREADY)
		else $error("ready too long");
	a_err_ready: assert property (PSLVERR |-> PREADY && PSEL && PENABLE)
		else $error("stray error");
	a_upper_zero: assert property (PREADY && !PWRITE |-> PRDATA[31:16] == 16'h0000)
		else $error("upper read bits set");
	a_rsvd_bits: assert property (PREADY && !PWRITE && PADDR[11:6] == 6'h01 |-> !PRDATA[4] && !PRDATA[2])
		else $error("unused bits set");
	a_result_lat: assert property (1'b1 |=> RESULT.valid == $past(FRAME.valid))
		else $error("result timing");
	a_fifo_route: assert property (RESULT.valid && RESULT.hit |-> RESULT.to_fifo == (RESULT.dest == 4'hf))
		else $error("fifo routing");
	a_low_dest: assert property (RESULT.valid && RESULT.hit && RESULT.filter < 4'hc
		|-> RESULT.dest == 4'($past(PTR_LOW) >> (4 * RESULT.filter)))
		else $error("wrong buffer");
endmodule

// ==== bench/can_acceptance_filter_config_test.sv ====
`timescale 1ns/1ns
`include "caf_regs.svh"
module can_acceptance_filter_config_test;
	import caf_pkg::*;
	logic CLK, NRST, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, er;
	logic [11:0] PADDR;
	logic [31:0] PWDATA, PRDATA, rd;
	caf_mask_s [2:0] MASKS;
	logic [47:0] PTR_LOW = 48'he0123456789a;
	logic [15:0] MSEL_HIGH = 16'h0000;
	caf_frame_s FRAME;
	caf_hit_s RESULT;
	int error_cnt = 0;
	int n_checks = 0;
	caf_top i_dut (.CLK(CLK), .NRST(NRST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
		.PWDATA(PWDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .PRDATA(PRDATA), .MASKS(MASKS),
		.PTR_LOW(PTR_LOW), .MSEL_HIGH(MSEL_HIGH), .FRAME(FRAME), .RESULT(RESULT));
	initial
	begin
		CLK = 0;
		forever #5 CLK = ~CLK;
	end
	////////////////////
	task conclude;
		$display("errors %0d checks %0d", error_cnt, n_checks);
		if (error_cnt == 0 && n_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task chk(input logic [31:0] g, input logic [31:0] e);
		n_checks++;
		if (g !== e)
		begin
			error_cnt++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	// Request held until the edge that samples ready
	task automatic apb(input logic w, input logic [11:0] a, input logic [15:0] d);
		int i;
		@(posedge CLK);
		PSEL <= 1'b1;
		PWRITE <= w;
		PADDR <= a;
		PWDATA <= {16'h0000, d};
		@(posedge CLK);
		PENABLE <= 1'b1;
		for (i = 0; i < 9 && PREADY !== 1'b1; i++)
			@(posedge CLK);
		if (PREADY !== 1'b1)
		begin
			error_cnt++;
			conclude();
		end
		rd = PRDATA;
		er = PSLVERR;
		PSEL <= 1'b0;
		PENABLE <= 1'b0;
	endtask
	// Misses compare only valid and hit
	task automatic fr(input logic x, input logic [10:0] s, input logic [17:0] e, input logic h,
		input logic [3:0] f, input logic [3:0] d);
		@(posedge CLK);
		FRAME <= {1'b1, x, s, e};
		@(posedge CLK);
		FRAME <= '0;
		@(posedge CLK);
		if (h)
			chk(32'(RESULT), 32'({2'b11, f, d, d == 4'hf}));
		else
			chk(32'({RESULT.valid, RESULT.hit}), 32'h2);
	endtask
	////////////////////
	task t_regs;
		apb(0, `CAF_OFS_FEN, 0);
		chk(rd, 32'h0000ffff);
		apb(0, `CAF_OFS_MSEL1, 0);
		chk(rd, 32'h0);
		apb(1, 12'h07c, 16'hffff);
		apb(0, 12'h07c, 0);
		chk(rd, 32'h0000ffeb);
		apb(0, 12'hffc, 0);
		chk(32'(er), 32'h1);
	endtask
	task automatic t_route;
		int n;
		apb(0, `CAF_OFS_PTR4, 0);
		chk(rd, 32'h0);
		apb(1, `CAF_OFS_PTR4, 16'hf3a5);
		for (n = 0; n < 16; n++)
		begin
			apb(1, `CAF_OFS_FEN, 16'(1 << n));
			fr(0, 0, 0, 1, 4'(n), n < 12 ? PTR_LOW[4*n +: 4] : 4'(16'hf3a5 >> (4 * (n - 12))));
		end
		apb(1, `CAF_OFS_FEN, 0);
		fr(0, 0, 0, 0, 0, 0);
	endtask
	task t_ident;
		MASKS[0] <= {1'b1, 11'h7ff, 18'h3ffff};
		apb(1, `CAF_OFS_FEN, 1);
		apb(1, `CAF_OFS_SID_BASE, 16'hb46a);
		apb(1, `CAF_OFS_EID_BASE, 16'hc3c3);
		fr(1, 11'h5a3, 18'h2c3c3, 1, 0, 4'ha);
		fr(1, 11'h5a2, 18'h2c3c3, 0, 0, 0);
		fr(1, 11'h5a3, 18'h0c3c3, 0, 0, 0);
		fr(1, 11'h5a3, 18'h2c3c2, 0, 0, 0);
		fr(0, 11'h5a3, 0, 0, 0, 0);
		apb(1, `CAF_OFS_SID_BASE, 16'hb462);
		fr(0, 11'h5a3, 0, 1, 0, 4'ha);
		fr(1, 11'h5a3, 18'h2c3c3, 0, 0, 0);
		MASKS[0].mask_identifier_type <= 1'b0;
		fr(1, 11'h5a3, 18'h2c3c3, 1, 0, 4'ha);
	endtask
	task automatic t_msel;
		int c;
		MASKS[2] <= MASKS[0];
		MASKS[1] <= '0;
		for (c = 0; c < 3; c++)
		begin
			apb(1, `CAF_OFS_MSEL1, 16'(c));
			fr(0, 11'h001, 0, c == 1, 0, 4'ha);
		end
		apb(1, `CAF_OFS_FEN, 16'h0080);
		fr(0, 11'h001, 0, 0, 0, 0);
		apb(1, `CAF_OFS_MSEL1, 16'h4000);
		fr(0, 11'h001, 0, 1, 7, 4'h3);
	endtask
	initial
	begin
		{PSEL, PENABLE, PWRITE, PADDR, PWDATA} = '0;
		MASKS = '0;
		FRAME = '0;
		NRST = 0;
		repeat (4) @(posedge CLK);
		NRST <= 1'b1;
		t_regs;
		t_route;
		t_ident;
		t_msel;
		conclude;
	end
endmodule
bind caf_top caf_chk #(.NUM_FILTERS(NUM_FILTERS)) i_chk (.CLK(CLK), .NRST(NRST), .PSEL(PSEL), .PENABLE(PENABLE),
	.PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .PRDATA(PRDATA),
	.MASKS(MASKS), .PTR_LOW(PTR_LOW), .MSEL_HIGH(MSEL_HIGH), .FRAME(FRAME), .RESULT(RESULT));

// ==== hw/caf_top.sv ====
`timescale 1ns/1ns
`include "caf_regs.svh"

// Functional notes
// - A hitting filter whose destination pointer is all ones sends the frame to the receive FIFO.
// - A pointer value from 0 to 14 sends the frame to the receive buffer of that number.
// - The pointer register for filters 12 to 15 holds filter 15 at 15-12, 14 at 11-8, 13 at 7-4, 12 at 3-0.
// - Bits 15-5 of a filter standard identifier register must equal each compared received standard bit.
// - With the mask type bit set, a filter whose extended-enable bit 3 is one matches only extended frames.
// - With the mask type bit set an extended-enable of zero matches only standard frames; with it clear the bit is ignored.
// - The eighteen extended bits are bits 1-0 of the standard register over the sixteen of the extended register.
// - Bits 4 and 2 of each filter standard identifier register always read as zero.
// - A filter's two-bit mask-source field picks mask 0, 1 or 2 for codes 00, 01, 10.
// - The mask-selection register for filters 0 to 7 holds filter 7 at 15-14 down to filter 0 at 1-0.
// - A filter takes part in acceptance only while its enable bit is one.
module caf_top
#(
	parameter int NUM_FILTERS = 16
)
(
	input wire logic CLK,
	input wire logic NRST,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [11:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic PREADY,
	output logic PSLVERR,
	output logic [31:0] PRDATA,
	input wire caf_pkg::caf_mask_s [2:0] MASKS,
	input wire logic [47:0] PTR_LOW,
	input wire logic [15:0] MSEL_HIGH,
	input wire caf_pkg::caf_frame_s FRAME,
	output caf_pkg::caf_hit_s RESULT
);
	import caf_pkg::*;

	caf_state_s r;
	caf_state_s next_r;
	logic [15:0] hit;
	logic [15:0][3:0] dest;
	logic [31:0] msel_all;
	logic [63:0] ptr_all;
	logic [16:0] below;
	logic [15:0] first;
	logic win_found;
	logic [3:0] win_idx;
	logic [31:0] rd_word;
	logic map_err;

	generate
		if (NUM_FILTERS != 16)
		begin : g_check
			$error("caf_top serves exactly sixteen filters");
		end
	endgenerate

	// The layout macros are shared with software; catch an edit that breaks the packing
	generate
		if (`CAF_SID_HI - `CAF_SID_LO != 10)
		begin : g_sid_check
			$error("standard identifier field must span eleven bits");
		end
		if (`CAF_PTR_W * 4 != 16)
		begin : g_ptr_check
			$error("four destination pointers must fill one sixteen-bit register");
		end
		if (`CAF_MSEL_W * 8 != 16)
		begin : g_msel_check
			$error("eight mask-source fields must fill one sixteen-bit register");
		end
		if ((`CAF_SID_WMASK & 16'h0014) != 16'h0000)
		begin : g_wmask_check
			$error("unimplemented standard register bits must stay cleared");
		end
		if (`CAF_DEST_FIFO != {`CAF_PTR_W{1'b1}})
		begin : g_fifo_check
			$error("the receive FIFO code must be all ones");
		end
		if ((`CAF_OFS_SID_BASE & ~`CAF_OFS_BANK_MASK) != 12'h000)
		begin : g_bank_check
			$error("identifier banks must start on a bank boundary");
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////
	// Per-filter matching

	assign msel_all = {MSEL_HIGH, r.msel1};
	assign ptr_all = {r.ptr4, PTR_LOW};

	// Prefix chain: below[k] is set when some filter under k hits
	assign below[0] = 1'b0;

	genvar gi;
	generate
		for (gi = 0; gi < 16; gi++)
		begin : g_flt
			logic [1:0] sel;
			caf_mask_s mk;
			logic [10:0] fsid;
			logic [17:0] feid;
			logic type_ok;
			logic sid_ok;
			logic eid_ok;
			assign sel = msel_all[gi * 2 +: 2];
			// Reserved code falls back to mask 0 here but never hits below
			assign mk = (sel == `CAF_MSEL_RSVD) ? MASKS[0] : MASKS[sel];
			assign fsid = r.std_identifier_bits[gi][`CAF_SID_HI:`CAF_SID_LO];
			assign feid = {r.std_identifier_bits[gi][`CAF_SID_EIDHI:0], r.ext_identifier_bits[gi]};
			// Type bit is only honoured when the chosen mask asks for it
			assign type_ok = !mk.mask_identifier_type || (r.std_identifier_bits[gi][`CAF_SID_FILTER_EXTENDED_ENABLE] == FRAME.ide);
			assign sid_ok = ((FRAME.std_identifier_bits ^ fsid) & mk.std_identifier_bits) == 11'h000;
			// A standard frame carries no extended bits, so they cannot mismatch
			assign eid_ok = !FRAME.ide || (((FRAME.ext_identifier_bits ^ feid) & mk.ext_identifier_bits) == 18'h00000);
			// A reserved selection never hits rather than guessing a mask
			assign hit[gi] = r.fen[gi] && (sel != `CAF_MSEL_RSVD) && type_ok && sid_ok && eid_ok;
			assign dest[gi] = ptr_all[gi * `CAF_PTR_W +: `CAF_PTR_W];
			assign below[gi + 1] = below[gi] || hit[gi];
			assign first[gi] = hit[gi] && !below[gi];
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////
	// Winner select

	// The chain leaves at most one first bit set, so OR-ing the indices is safe
	assign win_found = below[16];

	always_comb
	begin
		win_idx = 4'h0;
		for (int i = 0; i < 16; i++)
		begin
			if (first[i])
			begin
				win_idx = win_idx | 4'(i);
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Read data and address check

	always_comb
	begin
		rd_word = 32'h00000000;
		map_err = 1'b0;
		case (PADDR & `CAF_OFS_BANK_MASK)
			`CAF_OFS_SID_BASE:
			begin
				// Only whole aligned words are mapped
				if (PADDR[1:0] == 2'b00)
				begin
					rd_word = {16'h0000, r.std_identifier_bits[PADDR[5:2]] & `CAF_SID_WMASK};
				end
				else
				begin
					map_err = 1'b1;
				end
			end
			`CAF_OFS_EID_BASE:
			begin
				if (PADDR[1:0] == 2'b00)
				begin
					rd_word = {16'h0000, r.ext_identifier_bits[PADDR[5:2]]};
				end
				else
				begin
					map_err = 1'b1;
				end
			end
			default:
			begin
				case (PADDR)
					`CAF_OFS_FEN:
					begin
						rd_word = {16'h0000, r.fen};
					end
					`CAF_OFS_PTR4:
					begin
						rd_word = {16'h0000, r.ptr4};
					end
					`CAF_OFS_MSEL1:
					begin
						rd_word = {16'h0000, r.msel1};
					end
					`CAF_OFS_STAT:
					begin
						rd_word = {16'h0000, r.stat};
					end
					default:
					begin
						map_err = 1'b1;
					end
				endcase
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////////
	// Next state

	always_comb
	begin
		logic acc;
		logic wr;
		logic [11:0] bank;
		logic [3:0] idx;
		acc = 1'b0;
		wr = 1'b0;
		bank = 12'h000;
		idx = 4'h0;
		next_r = r;

		// Banks of sixteen words hold the per-filter identifier registers
		bank = PADDR & `CAF_OFS_BANK_MASK;
		idx = PADDR[5:2];

		// Slave handshake: two wait states, answer registered
		// The registered answer costs a cycle but keeps every output straight from a flop
		next_r.pready = 1'b0;
		next_r.pslverr = 1'b0;
		case (r.st)
			CAF_ST_IDLE:
			begin
				if (PSEL && PENABLE)
				begin
					next_r.st = CAF_ST_WAIT;
				end
			end
			CAF_ST_WAIT:
			begin
				next_r.st = CAF_ST_ACK;
				next_r.pready = 1'b1;
				next_r.pslverr = map_err;
				next_r.prdata = PWRITE ? 32'h00000000 : rd_word;
			end
			CAF_ST_ACK:
			begin
				acc = 1'b1;
				next_r.st = CAF_ST_IDLE;
			end
			default:
			begin
				next_r.st = CAF_ST_IDLE;
			end
		endcase
		if (r.st == CAF_ST_IDLE && PSEL && PENABLE)
		begin
			next_r.st = CAF_ST_WAIT;
		end

		wr = acc && PSEL && PENABLE && PWRITE && !map_err;
		if (wr)
		begin
			case (bank)
				`CAF_OFS_SID_BASE:
				begin
					// Unimplemented bits are dropped on the way in, and reads mask them again with CAF_SID_WMASK
					next_r.std_identifier_bits[idx] = PWDATA[15:0] & `CAF_SID_WMASK;
				end
				`CAF_OFS_EID_BASE:
				begin
					next_r.ext_identifier_bits[idx] = PWDATA[15:0];
				end
				default:
				begin
					// The status word is read-only; a write to it is acknowledged and dropped
					if (PADDR == `CAF_OFS_FEN)
					begin
						next_r.fen = PWDATA[15:0];
					end
					else if (PADDR == `CAF_OFS_PTR4)
					begin
						next_r.ptr4 = PWDATA[15:0];
					end
					else if (PADDR == `CAF_OFS_MSEL1)
					begin
						next_r.msel1 = PWDATA[15:0];
					end
				end
			endcase
		end

		// Lowest numbered hitting filter wins
		next_r.res = '0;
		next_r.res.valid = FRAME.valid;
		if (FRAME.valid)
		begin
			if (win_found)
			begin
				next_r.res.hit = 1'b1;
				next_r.res.filter = win_idx;
				next_r.res.dest = dest[win_idx];
				next_r.res.to_fifo = (dest[win_idx] == `CAF_DEST_FIFO);
			end
			next_r.stat = {6'h00, next_r.res.to_fifo, next_r.res.dest, next_r.res.filter, next_r.res.hit};
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// State register

	always_ff @(posedge CLK or negedge NRST)
	begin
		if (!NRST)
		begin
			r.st <= CAF_ST_IDLE;
			r.pready <= 1'b0;
			r.pslverr <= 1'b0;
			r.prdata <= 32'h00000000;
			r.fen <= `CAF_RST_FEN;
			r.ptr4 <= `CAF_RST_PTR4;
			r.msel1 <= `CAF_RST_MSEL1;
			r.std_identifier_bits <= '0;
			r.ext_identifier_bits <= '0;
			r.res <= '0;
			r.stat <= 16'h0000;
		end
		else
		begin
			r <= next_r;
		end
	end

	assign PREADY = r.pready;
	assign PSLVERR = r.pslverr;
	assign PRDATA = r.prdata;
	assign RESULT = r.res;

endmodule

// ==== inc/caf_pkg.sv ====
package caf_pkg;

	typedef enum logic [1:0]
	{
		CAF_ST_IDLE = 2'b00,
		CAF_ST_WAIT = 2'b01,
		CAF_ST_ACK = 2'b11
	} caf_apb_e;

	// Received frame identifier, valid for one cycle
	typedef struct packed
	{
		logic valid;
		logic ide;
		logic [10:0] std_identifier_bits;
		logic [17:0] ext_identifier_bits;
	} caf_frame_s;

	// One acceptance mask; a one bit means that position is compared
	typedef struct packed
	{
		logic mask_identifier_type;
		logic [10:0] std_identifier_bits;
		logic [17:0] ext_identifier_bits;
	} caf_mask_s;

	typedef struct packed
	{
		logic valid;
		logic hit;
		logic [3:0] filter;
		logic [3:0] dest;
		logic to_fifo;
	} caf_hit_s;

	typedef struct packed
	{
		caf_apb_e st;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
		logic [15:0] fen;
		logic [15:0] ptr4;
		logic [15:0] msel1;
		logic [15:0][15:0] std_identifier_bits;
		logic [15:0][15:0] ext_identifier_bits;
		caf_hit_s res;
		logic [15:0] stat;
	} caf_state_s;

endpackage

// ==== inc/caf_regs.svh ====
`ifndef CAF_REGS_SVH
`define CAF_REGS_SVH

// Byte offsets on the APB slave, low 12 address bits decoded
`define CAF_OFS_FEN 12'h000
`define CAF_OFS_PTR4 12'h004
`define CAF_OFS_MSEL1 12'h008
`define CAF_OFS_STAT 12'h00c
`define CAF_OFS_SID_BASE 12'h040
`define CAF_OFS_EID_BASE 12'h080
`define CAF_OFS_BANK_MASK 12'hfc0

// Reset values
`define CAF_RST_FEN 16'hffff
`define CAF_RST_PTR4 16'h0000
`define CAF_RST_MSEL1 16'h0000
`define CAF_RST_ID 16'h0000

// Standard identifier match register layout
`define CAF_SID_HI 15
`define CAF_SID_LO 5
`define CAF_SID_FILTER_EXTENDED_ENABLE 3
`define CAF_SID_EIDHI 1
`define CAF_SID_WMASK 16'hffeb

// Field encodings
`define CAF_DEST_FIFO 4'hf
`define CAF_MSEL_RSVD 2'h3
`define CAF_PTR_W 4
`define CAF_MSEL_W 2

`endif
